//--- qie_pkg.sv
// Constants, field layouts and state codes of the queue interrupt engine.
// Assumes one core clock; the engine and its users import this package.
package qie_pkg;
  // ----------------------------------------------------------------
  // Widths and command codes
  // ----------------------------------------------------------------
  localparam int QID_W = 11; // Queue number width
  localparam int VEC_W = 11; // Message vector width, 2K vectors
  localparam int MAP_W = 18; // Vector map entry width
  localparam int CTX_W = 76; // Ring context width
  localparam int STAT_W = 39; // Source status descriptor width
  localparam logic [3:0] SEL_VECTOR_MAP = 4'hC; // Select vector map
  localparam logic [3:0] SEL_RING_CTX = 4'h8; // Select ring context
  localparam logic [3:0] SEL_CIDX_UPDATE = 4'hF; // Consumer pointer update
  localparam logic [1:0] OP_WRITE = 2'h0; // context_write_op
  localparam logic [1:0] OP_READ = 2'h1; // context_read_op
  localparam logic [1:0] OP_CLEAR = 2'h2; // context_clear_op
  localparam logic [1:0] OP_INVAL = 2'h3; // context_invalidate_op
  localparam logic [15:0] CIDX_UPDATE_OFFSET = 16'h6400; // Software cidx port
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAP_H2C_AGG = 17; // h2c_aggregate_enable
  localparam int MAP_H2C_HI = 16; // or_ring_a
  localparam int MAP_H2C_LO = 9;
  localparam int MAP_C2H_AGG = 8; // c2h_aggregate_enable
  localparam int MAP_C2H_HI = 7; // or_ring_b
  localparam int MAP_C2H_LO = 0;
  localparam int CTX_PIDX_HI = 75;
  localparam int CTX_PIDX_LO = 64;
  localparam int CTX_SIZE_HI = 63;
  localparam int CTX_SIZE_LO = 61;
  localparam int CTX_BASE_HI = 60; // ring_base_upper
  localparam int CTX_BASE_LO = 9;
  localparam int CTX_COLOR = 8;
  localparam int CTX_STATE = 7; // interrupt_state
  localparam int CTX_VEC_HI = 5;
  localparam int CTX_VEC_LO = 1;
  localparam int CTX_VALID = 0;
  localparam int RING_PAGE_ENTRIES = 512; // 4 KB of 8 B entries
  localparam logic [10:0] ENT_RSVD = 11'h000; // Entry bits 49:39
  localparam logic [CTX_W-1:0] CTX_RESET = '0; // Cleared context
  // Source codes; bit 1 gives the direction
  localparam logic [1:0] SRC_MM_H2C = 2'h0;
  localparam logic [1:0] SRC_ST_H2C = 2'h1;
  localparam logic [1:0] SRC_MM_C2H = 2'h2;
  localparam logic [1:0] SRC_ST_C2H = 2'h3;
  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOOKUP = 3'h1,
    ST_CTX = 3'h2,
    ST_WRITE = 3'h3,
    ST_WAIT = 3'h4,
    ST_MSIX = 3'h5
  } qie_state_e;
endpackage

//--- qie_engine.sv
// Queue interrupt engine: vector map, ring contexts, ring writes, messages.
// Assumes a memory write port with completion pulse and a message port.
//
// Operation
// - Message vectors span 2K; vectors shareable.
// - Accept requests from four DMA sources.
// - Error interrupts raised independently of transfers.
// - 2K-entry vector map, two halves, looked up first.
// - Host-to-card half: enable bit 17, vector 16:9.
// - Card-to-host half: enable bit 8, vector 7:0.
// - Vector is message index or ring index.
// - Map selector 0xC; write and read only.
// - Direct: lookup then message, no ring write.
// - Aggregated: lookup, context, ring write, message.
// - Each ring belongs to one function.
// - Three pending requests per source tolerated; engine queues four in total, shared by all sources.
// - 256 ring contexts for 256 rings.
// - Size field 63:61 in 4 KB steps.
// - Context 60:9 holds base address 63:12.
// - Context vector 5:1, valid bit 0.
// - Before write update pidx, color, state.
// - Context selector 0x8; write, read, clear, invalidate.
// - Entries 8 B; color bit 63 flips on wrap.
// - Entry queue, direction, error flag fields.
// - Entry 38:0 copies source status descriptor.
// - Descriptor 34:33 holds source interrupt state.
// - Descriptor holds cumulative consumer, producer pointers.
// - Copy context color; toggle on wrap.
// - Cidx equal clears state, else resend message.
// - Message waits for write completion; keep accepting.
`timescale 1ns/1ps
module qie_engine
  import qie_pkg::*;
#(
  parameter int NUM_QUEUES = 2048,
  parameter int NUM_RINGS = 256,
  parameter int PEND_DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_src_i,
  input wire logic [QID_W-1:0] req_qid_i,
  input wire logic [STAT_W-1:0] req_stat_i,
  output logic req_ready_o,
  input wire logic err_valid_i,
  input wire logic [VEC_W-1:0] err_vector_i,
  output logic err_ready_o,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_sel_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [QID_W-1:0] cmd_index_i,
  input wire logic [CTX_W-1:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic cmd_done_o,
  output logic cmd_error_o,
  output logic [CTX_W-1:0] cmd_rdata_o,
  output logic mwr_valid_o,
  output logic [63:0] mwr_addr_o,
  output logic [63:0] mwr_data_o,
  input wire logic mwr_ready_i,
  input wire logic mwr_done_i,
  output logic msix_valid_o,
  output logic [VEC_W-1:0] msix_vector_o,
  input wire logic msix_ready_i
);
  // ----------------------------------------------------------------
  // Storage and registers
  // ----------------------------------------------------------------
  localparam int PEND_W = 2 + 1 + QID_W + STAT_W + VEC_W; // Queue entry
  localparam int PTR_W = (PEND_DEPTH > 1) ? $clog2(PEND_DEPTH) : 1;
  localparam int CNT_W = $clog2(PEND_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(PEND_DEPTH);

  logic [MAP_W-1:0] map_mem [NUM_QUEUES]; // Queue to vector map
  logic [CTX_W-1:0] ctx_mem [NUM_RINGS]; // Ring contexts
  logic [PEND_W-1:0] pend_mem [PEND_DEPTH]; // Pending requests
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] count_reg, count_next;
  qie_state_e state_reg, state_next;
  logic req_ready_reg, err_ready_reg, err_pend_reg;
  logic [VEC_W-1:0] err_vec_reg; // Held error vector
  logic cur_err_reg; // Current is error interrupt
  logic [1:0] cur_src_reg;
  logic [QID_W-1:0] cur_qid_reg;
  logic [STAT_W-1:0] cur_stat_reg;
  logic [7:0] cur_ring_reg; // Ring index from map
  logic cmd_ready_reg, cmd_done_reg, cmd_error_reg;
  logic [CTX_W-1:0] cmd_rdata_reg;
  logic mwr_valid_reg, msix_valid_reg;
  logic [63:0] mwr_addr_reg, mwr_data_reg;
  logic [VEC_W-1:0] msix_vec_reg, msix_vec_next;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Last entry index of a ring from its size code
  function automatic logic [11:0] ring_last(input logic [2:0] sz);
    logic [12:0] n;
    n = (13'(sz) + 13'h1) * 13'(RING_PAGE_ENTRIES);
    return n[11:0] - 12'h1;
  endfunction

  // Pointer step with wrap
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(PEND_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // Pending queue
  // ----------------------------------------------------------------
  wire cmd_take = cmd_valid_i & cmd_ready_reg; // Only true while idle
  wire pend_empty = (count_reg == '0);
  wire pop = (state_reg == ST_IDLE) & ~cmd_take & ~pend_empty;
  wire push_req = req_valid_i & req_ready_reg;
  wire push_err = err_pend_reg & ~push_req & (count_reg != CNT_FULL);
  wire push = push_req | push_err;
  wire [PEND_W-1:0] req_word = {1'b0, req_src_i, req_qid_i, req_stat_i, VEC_W'(0)};
  wire [PEND_W-1:0] err_word = {1'b1, 2'h0, QID_W'(0), STAT_W'(0), err_vec_reg};
  wire [PEND_W-1:0] head = pend_mem[rd_ptr_reg];
  wire head_err = head[PEND_W-1];
  wire [VEC_W-1:0] head_vec = head[VEC_W-1:0];

  // Occupancy after this cycle
  always_comb begin
    count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  end

  // Queue storage; a request push is written ahead of a held error
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      pend_mem[wr_ptr_reg] <= push_req ? req_word : err_word;
    end
  end

  // Queue pointers and ready flags
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      req_ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
      rd_ptr_reg <= pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
      count_reg <= count_next;
      req_ready_reg <= (count_next != CNT_FULL);
    end
  end

  // Error request holding flop
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      err_pend_reg <= 1'b0;
      err_ready_reg <= 1'b0;
      err_vec_reg <= '0;
    end else begin
      err_pend_reg <= (err_pend_reg & ~push_err) | (err_valid_i & err_ready_reg);
      err_ready_reg <= ~((err_pend_reg & ~push_err) | (err_valid_i & err_ready_reg));
      err_vec_reg <= (err_valid_i & err_ready_reg) ? err_vector_i : err_vec_reg;
    end
  end

  // ----------------------------------------------------------------
  // Map lookup and ring context decode
  // ----------------------------------------------------------------
  wire [MAP_W-1:0] map_word = map_mem[cur_qid_reg];
  wire to_c2h = cur_src_reg[1];
  wire agg = to_c2h ? map_word[MAP_C2H_AGG] : map_word[MAP_H2C_AGG];
  wire [7:0] map_vec = to_c2h ? map_word[MAP_C2H_HI:MAP_C2H_LO] :
                                map_word[MAP_H2C_HI:MAP_H2C_LO];
  wire [CTX_W-1:0] ctx_cur = ctx_mem[cur_ring_reg];
  wire [CTX_W-1:0] ctx_cmd = ctx_mem[cmd_index_i[7:0]];
  wire [11:0] pidx = ctx_cur[CTX_PIDX_HI:CTX_PIDX_LO];
  wire [51:0] base_upper = ctx_cur[CTX_BASE_HI:CTX_BASE_LO];
  wire ring_color = ctx_cur[CTX_COLOR];
  wire ctx_valid = ctx_cur[CTX_VALID];
  wire wrap = (pidx == ring_last(ctx_cur[CTX_SIZE_HI:CTX_SIZE_LO]));
  wire [11:0] pidx_new = wrap ? 12'h000 : pidx + 12'h001;
  wire color_new = wrap ? ~ring_color : ring_color;
  wire [63:0] ring_addr = {base_upper, 12'h000} + {49'h0, pidx, 3'h0};
  wire [63:0] ring_entry = {ring_color, cur_qid_reg, to_c2h, cur_err_reg,
                            ENT_RSVD, cur_stat_reg};
  wire [CTX_W-1:0] ctx_upd = {pidx_new, ctx_cur[CTX_SIZE_HI:CTX_BASE_LO],
                              color_new, 1'b1, ctx_cur[6:0]};

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire cmd_map = (cmd_sel_i == SEL_VECTOR_MAP);
  wire cmd_ctx = (cmd_sel_i == SEL_RING_CTX);
  wire cmd_cidx = (cmd_sel_i == SEL_CIDX_UPDATE);
  wire map_op_ok = (cmd_op_i == OP_WRITE) | (cmd_op_i == OP_READ);
  wire cmd_bad = (cmd_map & ~map_op_ok) | ~(cmd_map | cmd_ctx | cmd_cidx);
  wire cidx_hit = (cmd_data_i[11:0] == ctx_cmd[CTX_PIDX_HI:CTX_PIDX_LO]);
  wire cidx_resend = cmd_take & cmd_cidx & ~cidx_hit;
  wire cidx_clear = cmd_take & cmd_cidx & cidx_hit;

  // Vector map writes
  always_ff @(posedge core_clk_i) begin
    if (cmd_take & cmd_map & (cmd_op_i == OP_WRITE)) begin
      map_mem[cmd_index_i] <= cmd_data_i[MAP_W-1:0];
    end
  end

  // Ring context writes: engine update, software commands, cidx
  always_ff @(posedge core_clk_i) begin
    if ((state_reg == ST_CTX) & ctx_valid) begin
      ctx_mem[cur_ring_reg] <= ctx_upd;
    end else if (cmd_take & cmd_ctx) begin
      case (cmd_op_i)
        OP_WRITE: ctx_mem[cmd_index_i[7:0]] <= cmd_data_i;
        OP_CLEAR: ctx_mem[cmd_index_i[7:0]] <= CTX_RESET;
        OP_INVAL: ctx_mem[cmd_index_i[7:0]] <= {ctx_cmd[CTX_W-1:1], 1'b0};
        default: ;
      endcase
    end else if (cidx_clear) begin
      ctx_mem[cmd_index_i[7:0]] <= {ctx_cmd[CTX_W-1:8], 1'b0, ctx_cmd[6:0]};
    end
  end

  // Command answers, one cycle after acceptance
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cmd_done_reg <= 1'b0;
      cmd_error_reg <= 1'b0;
      cmd_rdata_reg <= '0;
    end else begin
      cmd_done_reg <= cmd_take;
      cmd_error_reg <= cmd_take & cmd_bad;
      if (cmd_take & (cmd_op_i == OP_READ)) begin
        cmd_rdata_reg <= cmd_map ? CTX_W'(map_mem[cmd_index_i]) : ctx_cmd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state and message vector
  always_comb begin
    state_next = state_reg;
    msix_vec_next = msix_vec_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cidx_resend) begin
          state_next = ST_MSIX;
          msix_vec_next = VEC_W'(ctx_cmd[CTX_VEC_HI:CTX_VEC_LO]);
        end else if (pop) begin
          state_next = head_err ? ST_MSIX : ST_LOOKUP;
          msix_vec_next = head_vec;
        end
      end
      ST_LOOKUP: begin
        state_next = agg ? ST_CTX : ST_MSIX;
        msix_vec_next = VEC_W'(map_vec);
      end
      ST_CTX: state_next = ctx_valid ? ST_WRITE : ST_IDLE;
      ST_WRITE: state_next = mwr_ready_i ? ST_WAIT : ST_WRITE;
      ST_WAIT: begin
        state_next = mwr_done_i ? ST_MSIX : ST_WAIT;
        msix_vec_next = VEC_W'(ctx_cur[CTX_VEC_HI:CTX_VEC_LO]);
      end
      ST_MSIX: state_next = msix_ready_i ? ST_IDLE : ST_MSIX;
      default: state_next = ST_IDLE;
    endcase
  end

  // Current request capture
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cur_err_reg <= 1'b0;
      cur_src_reg <= SRC_MM_H2C;
      cur_qid_reg <= '0;
      cur_stat_reg <= '0;
      cur_ring_reg <= '0;
    end else begin
      if (pop & ~cidx_resend) begin
        {cur_err_reg, cur_src_reg, cur_qid_reg, cur_stat_reg} <= head[PEND_W-1:VEC_W];
      end
      if (state_reg == ST_LOOKUP) begin
        cur_ring_reg <= map_vec;
      end
    end
  end

  // State and registered outputs
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      cmd_ready_reg <= 1'b0;
      mwr_valid_reg <= 1'b0;
      msix_valid_reg <= 1'b0;
      msix_vec_reg <= '0;
      mwr_addr_reg <= '0;
      mwr_data_reg <= '0;
    end else begin
      state_reg <= state_next;
      cmd_ready_reg <= (state_next == ST_IDLE);
      mwr_valid_reg <= (state_next == ST_WRITE);
      msix_valid_reg <= (state_next == ST_MSIX);
      msix_vec_reg <= msix_vec_next;
      if (state_reg == ST_CTX) begin
        mwr_addr_reg <= ring_addr;
        mwr_data_reg <= ring_entry;
      end
    end
  end

  assign req_ready_o = req_ready_reg;
  assign err_ready_o = err_ready_reg;
  assign cmd_ready_o = cmd_ready_reg;
  assign cmd_done_o = cmd_done_reg;
  assign cmd_error_o = cmd_error_reg;
  assign cmd_rdata_o = cmd_rdata_reg;
  assign mwr_valid_o = mwr_valid_reg;
  assign mwr_addr_o = mwr_addr_reg;
  assign mwr_data_o = mwr_data_reg;
  assign msix_valid_o = msix_valid_reg;
  assign msix_vector_o = msix_vec_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_msix_hold;
    msix_valid_o && !msix_ready_i |=> msix_valid_o && $stable(msix_vector_o);
  endproperty
  a_msix_hold: assert property (p_msix_hold) else $error("message dropped");
  property p_mwr_hold;
    mwr_valid_o && !mwr_ready_i |=> mwr_valid_o && $stable(mwr_data_o);
  endproperty
  a_mwr_hold: assert property (p_mwr_hold) else $error("ring write dropped");
  property p_write_first;
    state_reg == ST_WRITE |=> !msix_valid_o [*2];
  endproperty
  a_write_first: assert property (p_write_first) else $error("early message");
  property p_wait_done;
    state_reg == ST_WAIT && mwr_done_i |=> msix_valid_o;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("no message");
  property p_align;
    mwr_valid_o |-> mwr_addr_o[2:0] == 3'h0;
  endproperty
  a_align: assert property (p_align) else $error("entry misaligned");
  // Ready is still low at the first edge after reset, so skip that edge
  property p_pend_bound;
    count_reg <= CNT_FULL && ($past(reset_i) || req_ready_o == (count_reg != CNT_FULL));
  endproperty
  a_pend_bound: assert property (p_pend_bound) else $error("queue overrun");
  property p_cmd_done;
    cmd_take |=> cmd_done_o ##1 (cmd_done_o == $past(cmd_take));
  endproperty
  a_cmd_done: assert property (p_cmd_done) else $error("no command answer");
  property p_map_bad;
    cmd_take && cmd_map && cmd_op_i == OP_CLEAR |=> cmd_error_o;
  endproperty
  a_map_bad: assert property (p_map_bad) else $error("clear on map taken");
  property p_direct;
    state_reg == ST_LOOKUP && !agg |=> msix_valid_o && msix_vector_o[7:0] == $past(map_vec);
  endproperty
  a_direct: assert property (p_direct) else $error("bad direct vector");

  c_direct: cover property (state_reg == ST_LOOKUP && !agg);
  c_ring: cover property (mwr_valid_o && mwr_ready_i);
  c_resend: cover property (cidx_resend);
endmodule

//--- qie_pcie_model.sv
// Far-side model: PCIe core taking ring writes and interrupt messages.
// Assumes the engine holds valid and data until ready; one clock.
`timescale 1ns/1ps
module qie_pcie_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic mwr_valid_i,
  output logic mwr_ready_o,
  output logic mwr_done_o,
  input wire logic msix_valid_i,
  output logic msix_ready_o
);
  logic [2:0] wwait_reg; // Write stall left
  logic [2:0] dwait_reg; // Cycles to completion
  logic [2:0] mwait_reg; // Message stall left
  // ----------------------------------------------------------------
  // Accept after a stall, complete writes later
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      {mwr_ready_o, mwr_done_o, msix_ready_o} <= 3'h0;
      {wwait_reg, dwait_reg, mwait_reg} <= 9'h000;
    end else begin
      mwr_ready_o <= mwr_valid_i && !mwr_ready_o && wwait_reg == 3'h0;
      msix_ready_o <= msix_valid_i && !msix_ready_o && mwait_reg == 3'h0;
      if (mwr_valid_i && !mwr_ready_o && wwait_reg != 3'h0) begin
        wwait_reg <= wwait_reg - 3'h1;
      end
      if (msix_valid_i && !msix_ready_o && mwait_reg != 3'h0) begin
        mwait_reg <= mwait_reg - 3'h1;
      end
      if (msix_valid_i && msix_ready_o) begin
        mwait_reg <= slow_i ? 3'h2 : 3'h0;
      end
      // Completion only after the write was accepted
      if (mwr_valid_i && mwr_ready_o) begin
        wwait_reg <= slow_i ? 3'h3 : 3'h0;
        dwait_reg <= slow_i ? 3'h5 : 3'h1;
      end else if (dwait_reg != 3'h0) begin
        dwait_reg <= dwait_reg - 3'h1;
      end
      mwr_done_o <= dwait_reg == 3'h1;
    end
  end
endmodule

//--- qie_engine_bench.sv
// Self-checking bench: driver queues expectations, monitor compares.
// Assumes qie_pkg, qie_engine and qie_pcie_model are compiled first.
`timescale 1ns/1ps
module qie_engine_bench;
  import qie_pkg::*;
  logic clk = 1'h0, rst = 1'h1, slow = 1'h0;
  logic rq_v = 1'h0, rq_rdy, er_v = 1'h0, er_rdy, c_v = 1'h0, c_rdy, c_done, c_err;
  logic [1:0] rq_src = 2'h0, c_op = 2'h0;
  logic [QID_W-1:0] rq_qid = '0, c_idx = '0;
  logic [STAT_W-1:0] rq_stat = '0;
  logic [VEC_W-1:0] er_vec = '0, m_vec;
  logic [3:0] c_sel = 4'h0;
  logic [CTX_W-1:0] c_data = '0, c_rdata, d;
  logic w_v, w_rdy, w_done, m_v, m_rdy;
  logic [63:0] w_addr, w_data;
  logic [VEC_W-1:0] q_vec[$]; // Expected message vectors
  logic [127:0] q_wr[$]; // Expected ring write address and entry
  logic [CTX_W+1:0] q_cmd[$]; // Expected read flag, error, read data
  logic [CTX_W+1:0] e;
  logic [MAP_W-1:0] map_m [0:2047]; // Vector map as software sees it
  logic [CTX_W-1:0] ctx_m [0:255]; // Ring contexts as software sees it
  int num_errors = 0, n_compared = 0, pend = 0, stalls = 0, i, sz;
  integer seed = 32'hB98B;

  qie_engine i_qie_engine (.core_clk_i(clk), .reset_i(rst), .req_valid_i(rq_v),
    .req_src_i(rq_src), .req_qid_i(rq_qid), .req_stat_i(rq_stat), .req_ready_o(rq_rdy),
    .err_valid_i(er_v), .err_vector_i(er_vec), .err_ready_o(er_rdy), .cmd_valid_i(c_v),
    .cmd_sel_i(c_sel), .cmd_op_i(c_op), .cmd_index_i(c_idx), .cmd_data_i(c_data),
    .cmd_ready_o(c_rdy), .cmd_done_o(c_done), .cmd_error_o(c_err), .cmd_rdata_o(c_rdata),
    .mwr_valid_o(w_v), .mwr_addr_o(w_addr), .mwr_data_o(w_data), .mwr_ready_i(w_rdy),
    .mwr_done_i(w_done), .msix_valid_o(m_v), .msix_vector_o(m_vec), .msix_ready_i(m_rdy));
  qie_pcie_model i_qie_pcie_model (.core_clk_i(clk), .reset_i(rst), .slow_i(slow),
    .mwr_valid_i(w_v), .mwr_ready_o(w_rdy), .mwr_done_o(w_done), .msix_valid_i(m_v),
    .msix_ready_o(m_rdy));

  always #50 clk = ~clk; // 10 MHz

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] x, input logic [127:0] g);
    n_compared++;
    if (x !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, x, g);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Hold the request until ready is seen at an edge (0 req, 1 err, 2 cmd)
  task automatic take(input int k);
    int j;
    for (j = 0; j < 400 && (k == 0 ? rq_rdy : k == 1 ? er_rdy : c_rdy) !== 1'h1; j++) tick();
    if (k == 0) stalls += j;
    if (j == 400) begin
      chk("ready_wait", 0, 1);
      conclude();
    end
    tick();
  endtask
  task automatic drain(input string name);
    int j;
    for (j = 0; j < 3000 && q_vec.size() + q_wr.size() + q_cmd.size() != 0; j++) tick();
    if (j == 3000) begin
      chk("drain_wait", 0, 1);
      conclude();
    end
    repeat (20) tick();
    $display("test %s done, mismatches %0d", name, num_errors);
  endtask
  task automatic send_req(input logic [1:0] src, input logic [QID_W-1:0] qid);
    logic [MAP_W-1:0] m;
    logic [7:0] v;
    logic [CTX_W-1:0] c;
    int n;
    m = map_m[qid];
    v = src[1] ? m[MAP_C2H_HI:MAP_C2H_LO] : m[MAP_H2C_HI:MAP_H2C_LO];
    rq_src = src;
    rq_qid = qid;
    rq_stat = STAT_W'({$random(seed), $random(seed)});
    rq_v = 1'h1;
    take(0);
    c = ctx_m[v];
    n = (int'(c[CTX_SIZE_HI:CTX_SIZE_LO]) + 1) * RING_PAGE_ENTRIES;
    if (!(src[1] ? m[MAP_C2H_AGG] : m[MAP_H2C_AGG])) q_vec.push_back(VEC_W'(v));
    else if (c[CTX_VALID]) begin
      q_wr.push_back({{c[CTX_BASE_HI:CTX_BASE_LO], 12'h000} + {49'h0, c[CTX_PIDX_HI:
        CTX_PIDX_LO], 3'h0}, c[CTX_COLOR], qid, src[1], 1'h0, ENT_RSVD, rq_stat});
      q_vec.push_back(VEC_W'(c[CTX_VEC_HI:CTX_VEC_LO]));
      c[CTX_STATE] = 1'h1;
      c[CTX_PIDX_HI:CTX_PIDX_LO] += 12'h001;
      if (c[CTX_PIDX_HI:CTX_PIDX_LO] == 12'(n)) begin
        c[CTX_PIDX_HI:CTX_PIDX_LO] = 12'h000;
        c[CTX_COLOR] = ~c[CTX_COLOR];
      end
      ctx_m[v] = c;
    end
  endtask
  task automatic send_err(input logic [VEC_W-1:0] v);
    er_vec = v;
    er_v = 1'h1;
    take(1);
    er_v = 1'h0;
    q_vec.push_back(v);
  endtask
  task automatic do_cmd(input logic [3:0] sel, input logic [1:0] op, input logic [7:0] idx,
                        input logic [CTX_W-1:0] dat);
    logic bad;
    bad = !(sel == SEL_RING_CTX || sel == SEL_CIDX_UPDATE || (sel == SEL_VECTOR_MAP
            && op <= OP_READ));
    q_cmd.push_back({op == OP_READ && !bad, bad,
                     sel == SEL_VECTOR_MAP ? CTX_W'(map_m[idx]) : ctx_m[idx]});
    c_sel = sel;
    c_op = op;
    c_idx = QID_W'(idx);
    c_data = dat;
    c_v = 1'h1;
    take(2);
    chk("cmd_done", 1, c_done);
    c_v = 1'h0;
    if (!bad && sel == SEL_VECTOR_MAP && op == OP_WRITE) map_m[idx] = dat[MAP_W-1:0];
    if (!bad && sel == SEL_RING_CTX) begin
      case (op)
        OP_WRITE: ctx_m[idx] = dat;
        OP_CLEAR: ctx_m[idx] = CTX_RESET;
        OP_INVAL: ctx_m[idx][CTX_VALID] = 1'h0;
        default: ;
      endcase
    end
    if (sel == SEL_CIDX_UPDATE) begin
      if (dat[11:0] == ctx_m[idx][CTX_PIDX_HI:CTX_PIDX_LO]) ctx_m[idx][CTX_STATE] = 1'h0;
      else q_vec.push_back(VEC_W'(ctx_m[idx][CTX_VEC_HI:CTX_VEC_LO]));
    end
    tick();
  endtask

  // ----------------------------------------------------------------
  // Monitor: pops the oldest note whenever a result appears
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (!rst) begin
      if (m_v === 1'h1 && m_rdy === 1'h1) begin
        chk("write_outstanding", 0, pend);
        if (q_vec.size() == 0) chk("msix_unexpected", 0, 1);
        else chk("msix_vector", q_vec.pop_front(), m_vec);
      end
      if (w_v === 1'h1 && w_rdy === 1'h1) begin
        pend++;
        if (q_wr.size() == 0) chk("ring_write_unexpected", 0, 1);
        else chk("ring_write", q_wr.pop_front(), {w_addr, w_data});
      end
      if (w_done === 1'h1) pend--;
      if (c_done === 1'h1) begin
        if (q_cmd.size() == 0) chk("cmd_unexpected", 0, 1);
        else begin
          e = q_cmd.pop_front();
          chk("cmd_error", e[CTX_W], c_err);
          if (e[CTX_W+1]) chk("cmd_rdata", e[CTX_W-1:0], c_rdata);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) tick();
    rst = 1'h0;
    tick();
    // Map: direct queue 5, aggregated queue 6, queue 7 to ring 3
    do_cmd(SEL_VECTOR_MAP, OP_WRITE, 8'h05, CTX_W'({1'h0, 8'hA5, 1'h0, 8'h3C}));
    do_cmd(SEL_VECTOR_MAP, OP_WRITE, 8'h06, CTX_W'({1'h1, 8'h02, 1'h1, 8'h09}));
    do_cmd(SEL_VECTOR_MAP, OP_WRITE, 8'h07, CTX_W'({1'h0, 8'h11, 1'h1, 8'h03}));
    do_cmd(SEL_VECTOR_MAP, OP_CLEAR, 8'h05, '0);
    do_cmd(SEL_VECTOR_MAP, OP_INVAL, 8'h06, '0);
    do_cmd(4'h1, OP_WRITE, 8'h05, '0);
    for (i = 5; i < 8; i++) do_cmd(SEL_VECTOR_MAP, OP_READ, 8'(i), '0);
    drain("vector_map");
    for (i = 0; i < 4; i++) send_req(2'(i), 11'h005);
    rq_v = 1'h0;
    send_err(VEC_W'($random(seed)));
    drain("direct");
    do_cmd(SEL_RING_CTX, OP_WRITE, 8'h09, {64'h0, 4'h1, 8'h0B});
    // Every ring size, producer index one short of the end
    for (sz = 0; sz < 8; sz++) begin
      d = {12'((sz + 1) * RING_PAGE_ENTRIES - 1), 3'(sz), 52'({$random(seed), $random(seed)}),
           3'h4, 5'($random(seed)), 1'h1};
      do_cmd(SEL_RING_CTX, OP_WRITE, 8'h02, d);
      send_req(2'h0, 11'h006);
      send_req(2'h1, 11'h006);
      send_req(2'(2 + sz % 2), 11'h006);
      rq_v = 1'h0;
      drain("ring_size");
      do_cmd(SEL_RING_CTX, OP_READ, 8'h02, '0);
    end
    // Back-to-back burst against a stalling far side
    slow = 1'h1;
    for (i = 0; i < 10; i++) send_req(2'($random(seed)), 11'(5 + i % 2));
    rq_v = 1'h0;
    send_err(11'h7FF);
    drain("burst");
    slow = 1'h0;
    chk("refused_cycles", 1, stalls > 2);
    // Consumer pointer: one past producer, then equal
    do_cmd(SEL_CIDX_UPDATE, OP_WRITE, 8'h02, CTX_W'(ctx_m[2][CTX_PIDX_HI:CTX_PIDX_LO] + 1));
    do_cmd(SEL_CIDX_UPDATE, OP_WRITE, 8'h02, CTX_W'(ctx_m[2][CTX_PIDX_HI:CTX_PIDX_LO]));
    do_cmd(SEL_RING_CTX, OP_READ, 8'h02, '0);
    drain("consumer_update");
    // Invalidated ring drops the request, clear wipes the context
    do_cmd(SEL_RING_CTX, OP_WRITE, 8'h03, {64'h0, 4'h1, 8'h05});
    do_cmd(SEL_RING_CTX, OP_INVAL, 8'h03, '0);
    do_cmd(SEL_RING_CTX, OP_READ, 8'h03, '0);
    send_req(2'h2, 11'h007);
    rq_v = 1'h0;
    do_cmd(SEL_RING_CTX, OP_CLEAR, 8'h02, '0);
    do_cmd(SEL_RING_CTX, OP_READ, 8'h02, '0);
    drain("invalidate_clear");
    conclude();
  end
endmodule
